/* File: hw/lcs_pkg.sv */
/*
 * Shared constants and carrier types for the linear image sensor readout model.
 * Assumes one system clock (mclk, 20 MHz) that samples all sensor clock pins as levels.
 */
package lcs_pkg;

  // ****************************************
  // line geometry
  // ****************************************
  localparam int LCS_NUM_PIX = 2048;
  localparam int LCS_NUM_BLACK = 4;
  localparam int LCS_NUM_WHITE = 2;
  localparam int LCS_BLACK_A_END = LCS_NUM_BLACK;
  localparam int LCS_PIX_END = LCS_BLACK_A_END + LCS_NUM_PIX;
  localparam int LCS_BLACK_B_END = LCS_PIX_END + LCS_NUM_BLACK;
  localparam int LCS_WHITE_END = LCS_BLACK_B_END + LCS_NUM_WHITE;
  // minimum reset clock periods between transfers, above the 2058 a full line takes to leave the transport registers
  localparam int LCS_MIN_LINE_PERIODS = 2081;
  localparam int LCS_SEQ_W = 12;

  // ****************************************
  // levels
  // ****************************************
  localparam int LCS_CHG_W = 16;
  localparam int LCS_ILL_W = 8;
  localparam logic [15:0] LCS_FULL_SCALE = 16'hffff;
  localparam logic [15:0] LCS_BLACK_LEVEL = 16'h0000;
  // white reference sits near 70 percent of full scale
  localparam logic [15:0] LCS_WHITE_LEVEL = 16'((32'(LCS_FULL_SCALE) * 7) / 10);

  // ****************************************
  // timing
  // ****************************************
  localparam int LCS_MCLK_NS = 50;
  localparam int LCS_RCK_MAX_MHZ = 10;
  localparam int LCS_RCK_MIN_NS = 1000 / LCS_RCK_MAX_MHZ;
  localparam int LCS_RCK_MIN_CYC = (LCS_RCK_MIN_NS + LCS_MCLK_NS - 1) / LCS_MCLK_NS;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic charge_transfer_clock;
    logic transport_clk;
    logic detector_reset_clock;
    logic white_ref_clock;
  } lcs_clk_in_type;

  typedef enum logic [1:0] {
    LCS_ST_IDLE = 2'b00,
    LCS_ST_HOLD = 2'b01,
    LCS_ST_READ = 2'b10
  } lcs_state_type;

  typedef enum logic [1:0] {
    LCS_K_NONE = 2'b00,
    LCS_K_BLACK = 2'b01,
    LCS_K_PIX = 2'b10,
    LCS_K_WHITE = 2'b11
  } lcs_kind_type;

endpackage

/* File: hw/lcs_sensor.sv */
/*
 * Behavioural digital model of a 2048-element linear charge-coupled sensor:
 * exposure, transfer, odd/even transport merge, references and scan-end pulse.
 * Assumes the timing generator drives the sensor clock pins synchronously to mclk
 * and holds each detector reset clock level for at least one mclk period.
 */
// Functional notes
// - 2048 photosites integrate light over exposure time
// - transfer high fills well, low loads registers
// - odd/even packets split, re-merged in order
// - four black samples at each line end
// - injected charge gives two white reference samples
// - reset clock gives one sample per period
// - scan-end coincides with first white sample
// - scan-end comes one sample before line fully shifted out; the model pulses it only on lines where white charge was injected
// - one sample per period, at most 10 MHz
`timescale 1ns/10ps
module lcs_sensor
  import lcs_pkg::*;
#(
  parameter int NUM_PIX = LCS_NUM_PIX
) (
  // system
  input wire logic mclk,
  input wire logic sys_rst,
  // sensor clock pins
  input wire lcs_clk_in_type clk_in,
  // illumination onto one addressed photosite per cycle
  input wire logic illum_valid,
  input wire logic [LCS_SEQ_W-1:0] illum_addr,
  input wire logic [LCS_ILL_W-1:0] illum_level,
  // video side
  output logic [LCS_CHG_W-1:0] video_output,
  output logic video_valid,
  output logic scan_end_pulse
);

  // ****************************************
  // storage
  // ****************************************
  logic [LCS_CHG_W-1:0] accum_r [NUM_PIX];
  logic [LCS_CHG_W-1:0] well_r [NUM_PIX];
  logic [LCS_CHG_W-1:0] accum_nxt [NUM_PIX];
  logic [LCS_CHG_W-1:0] well_nxt [NUM_PIX];
  lcs_clk_in_type prev_r;
  lcs_state_type state_r, state_nxt;
  logic [LCS_SEQ_W-1:0] seq_r, seq_nxt;
  logic white_seen_r, white_seen_nxt;
  logic white_arm_r, white_arm_nxt;
  logic [LCS_CHG_W-1:0] video_r, video_nxt;
  logic valid_r, valid_nxt;
  logic eos_r, eos_nxt;
  lcs_kind_type kind_r, kind_nxt;

  logic xfer_rise, xfer_fall, rck_rise, wr_fall;
  logic [LCS_SEQ_W-1:0] pix_idx;

  function automatic logic [LCS_CHG_W-1:0] sat_add(input logic [LCS_CHG_W-1:0] a,
                                                   input logic [LCS_ILL_W-1:0] b);
    logic [LCS_CHG_W:0] s;
    s = {1'b0, a} + {{(LCS_CHG_W-LCS_ILL_W+1){1'b0}}, b};
    return s[LCS_CHG_W] ? LCS_FULL_SCALE : s[LCS_CHG_W-1:0];
  endfunction

  assign xfer_rise = clk_in.charge_transfer_clock && !prev_r.charge_transfer_clock;
  assign xfer_fall = !clk_in.charge_transfer_clock && prev_r.charge_transfer_clock;
  assign rck_rise = clk_in.detector_reset_clock && !prev_r.detector_reset_clock;
  assign wr_fall = !clk_in.white_ref_clock && prev_r.white_ref_clock;
  // even samples come from one transport path, odd from the other; the merge
  // restores photosite order, so the index is the line position less the four leading black samples
  assign pix_idx = seq_r - LCS_SEQ_W'(LCS_BLACK_A_END);

  // ****************************************
  // photosites and storage well
  // ****************************************
  always_comb begin
    accum_nxt = accum_r;
    well_nxt = well_r;
    if (xfer_rise) begin
      // exposure ends: charge moves to the well, photosite restarts empty
      well_nxt = accum_r;
      for (int i = 0; i < NUM_PIX; i++) begin
        accum_nxt[i] = '0;
      end
    end else begin
      for (int i = 0; i < NUM_PIX; i++) begin
        if (illum_valid && illum_addr == LCS_SEQ_W'(i)) begin
          accum_nxt[i] = sat_add(accum_r[i], illum_level);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_PIX; i++) begin
        accum_r[i] <= '0;
        well_r[i] <= '0;
      end
    end else begin
      accum_r <= accum_nxt;
      well_r <= well_nxt;
    end
  end

  // ****************************************
  // readout sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    seq_nxt = seq_r;
    white_seen_nxt = white_seen_r || wr_fall;
    white_arm_nxt = white_arm_r;
    video_nxt = video_r;
    valid_nxt = 1'b0;
    eos_nxt = eos_r;
    kind_nxt = kind_r;
    if (xfer_rise) begin
      // a held-high white clock never falls, so nothing gets injected
      state_nxt = LCS_ST_HOLD;
      white_arm_nxt = white_seen_r || wr_fall;
      white_seen_nxt = 1'b0;
    end else if (xfer_fall && state_r == LCS_ST_HOLD) begin
      state_nxt = LCS_ST_READ;
      seq_nxt = '0;
    end else if (rck_rise) begin
      // each reset pulse clears the sense node and presents one sample
      valid_nxt = 1'b1;
      eos_nxt = 1'b0;
      video_nxt = LCS_BLACK_LEVEL;
      kind_nxt = LCS_K_NONE;
      if (state_r == LCS_ST_READ) begin
        seq_nxt = seq_r + LCS_SEQ_W'(1);
        if (seq_r < LCS_SEQ_W'(LCS_BLACK_A_END)) begin
          kind_nxt = LCS_K_BLACK;
        end else if (seq_r < LCS_SEQ_W'(LCS_PIX_END)) begin
          kind_nxt = LCS_K_PIX;
          video_nxt = well_r[pix_idx[10:0]];
        end else if (seq_r < LCS_SEQ_W'(LCS_BLACK_B_END)) begin
          kind_nxt = LCS_K_BLACK;
        end else if (seq_r < LCS_SEQ_W'(LCS_WHITE_END)) begin
          if (white_arm_r) begin
            kind_nxt = LCS_K_WHITE;
            video_nxt = LCS_WHITE_LEVEL;
            eos_nxt = (seq_r == LCS_SEQ_W'(LCS_BLACK_B_END));
          end
          if (seq_r == LCS_SEQ_W'(LCS_WHITE_END - 1)) begin
            // registers now hold only flushed dark charge
            state_nxt = LCS_ST_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_r <= '0;
      state_r <= LCS_ST_IDLE;
      seq_r <= '0;
      white_seen_r <= 1'b0;
      white_arm_r <= 1'b0;
      video_r <= '0;
      valid_r <= 1'b0;
      eos_r <= 1'b0;
      kind_r <= LCS_K_NONE;
    end else begin
      prev_r <= clk_in;
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      white_seen_r <= white_seen_nxt;
      white_arm_r <= white_arm_nxt;
      video_r <= video_nxt;
      valid_r <= valid_nxt;
      eos_r <= eos_nxt;
      kind_r <= kind_nxt;
    end
  end

  assign video_output = video_r;
  assign video_valid = valid_r;
  assign scan_end_pulse = eos_r;

  // ****************************************
  // checks
  // ****************************************
  AST_PHOTO_INTEGRATE: assert property (@(posedge mclk) disable iff (sys_rst)
    (illum_valid && !xfer_rise && illum_addr == '0 && illum_level != '0
      && accum_r[0] != LCS_FULL_SCALE) |=> (accum_r[0] > $past(accum_r[0])))
    else $error("photosite did not integrate light");

  AST_WELL_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    xfer_rise |=> (state_r == LCS_ST_HOLD && well_r[0] == $past(accum_r[0]) && accum_r[0] == '0))
    else $error("transfer rise did not fill the well");

  AST_READ_START: assert property (@(posedge mclk) disable iff (sys_rst)
    (xfer_fall && state_r == LCS_ST_HOLD) |=> (state_r == LCS_ST_READ && seq_r == '0))
    else $error("transfer fall did not start readout");

  AST_PIX_ORDER: assert property (@(posedge mclk) disable iff (sys_rst)
    (kind_nxt == LCS_K_PIX && rck_rise) |=> (video_r == well_r[$past(pix_idx[10:0])]))
    else $error("pixel sample out of order");

  AST_BLACK_REF: assert property (@(posedge mclk) disable iff (sys_rst)
    (valid_r && kind_r == LCS_K_BLACK) |-> (video_r == LCS_BLACK_LEVEL))
    else $error("black reference sample not black");

  AST_WHITE_ARMED: assert property (@(posedge mclk) disable iff (sys_rst)
    (valid_r && kind_r == LCS_K_WHITE) |-> (white_arm_r && video_r == LCS_WHITE_LEVEL))
    else $error("white reference without injection");

  AST_ONE_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
    rck_rise |=> valid_r ##1 !valid_r)
    else $error("reset period did not give exactly one sample");

  AST_NO_STRAY_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
    valid_r |-> $past(rck_rise))
    else $error("sample without reset clock rise");

  AST_EOS_WITH_WHITE: assert property (@(posedge mclk) disable iff (sys_rst)
    scan_end_pulse |-> (kind_r == LCS_K_WHITE && seq_r == LCS_SEQ_W'(LCS_BLACK_B_END + 1)))
    else $error("scan-end not on first white sample");

  AST_EOS_END: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(scan_end_pulse) ##1 rck_rise
      |=> (state_r == LCS_ST_IDLE || state_r == LCS_ST_HOLD))
    else $error("readout still running after last white sample");

endmodule

/* File: test/lcs_tgen.sv */
/*
 * Timing generator model that drives the sensor clock pins of the readout model.
 * Assumes a 20 MHz mclk; every pin changes by non-blocking assignment on its edge.
 */
`timescale 1ns/10ps
module lcs_tgen
  import lcs_pkg::*;
#(
  parameter int PER = LCS_MIN_LINE_PERIODS
) (
  // system
  input wire logic mclk,
  input wire logic sys_rst,
  // white reference held high while set
  input wire logic white_hold,
  // sensor pins and pacing
  output lcs_clk_in_type clk_in,
  output logic quiet,
  output int lines
);
  // ****************************************
  // clock sequencing
  // ****************************************
  logic rck_r, tck_r, xfer_r, wr_r;
  int cnt_r;
  assign clk_in = '{charge_transfer_clock: xfer_r, transport_clk: tck_r,
                    detector_reset_clock: rck_r, white_ref_clock: wr_r};
  // keeps light away from the cycles around a transfer edge
  assign quiet = (cnt_r >= PER - 4) || xfer_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {rck_r, tck_r, xfer_r, wr_r} <= 4'h0;
      cnt_r <= 0;
      lines <= 0;
    end else begin
      rck_r <= ~rck_r;
      if (!rck_r) begin
        tck_r <= ~tck_r;
        cnt_r <= cnt_r + 1;
      end else if (xfer_r && !tck_r) begin
        // one cycle after transport fell, one before it rises
        xfer_r <= 1'b0;
        wr_r <= white_hold;
      end else if (!xfer_r && tck_r && cnt_r >= PER) begin
        xfer_r <= 1'b1;
        wr_r <= 1'b1;
        cnt_r <= 0;
        lines <= lines + 1;
      end else if (!xfer_r) begin
        wr_r <= white_hold;
      end
    end
  end
endmodule

/* File: test/linear_ccd_clock_sequencer_tb_top.sv */
/*
 * Self-checking bench: a queue-based line model predicts every video sample.
 * Assumes lcs_tgen drives the clock pins and the bench drives light and reset.
 */
`timescale 1ns/10ps
module linear_ccd_clock_sequencer_tb_top
  import lcs_pkg::*;
;
  // ****************************************
  // stimulus and model
  // ****************************************
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic illum_valid = 1'b0;
  logic white_hold = 1'b0;
  logic [LCS_SEQ_W-1:0] illum_addr = '0;
  logic [LCS_ILL_W-1:0] illum_level = '0;
  lcs_clk_in_type clk_in, prv;
  logic [LCS_CHG_W-1:0] video_output;
  logic video_valid, scan_end_pulse, quiet, xr, xf, rr, s;
  int lines, v, st, seq, fails = 0, compares = 0;
  int acc[LCS_NUM_PIX], well[LCS_NUM_PIX], qv[$];
  bit armed, line_arm, qs[$];

  always #25 mclk = ~mclk;

  lcs_tgen gen_u (.mclk(mclk), .sys_rst(sys_rst), .white_hold(white_hold), .clk_in(clk_in),
    .quiet(quiet), .lines(lines));
  lcs_sensor dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_in(clk_in), .illum_valid(illum_valid),
    .illum_addr(illum_addr), .illum_level(illum_level), .video_output(video_output),
    .video_valid(video_valid), .scan_end_pulse(scan_end_pulse));

  task chk(input logic [LCS_CHG_W-1:0] seen, input logic [LCS_CHG_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (sys_rst) begin
      prv = '0;
      st = 0;
      armed = 0;
      qv.delete();
      qs.delete();
      foreach (acc[i]) acc[i] = 0;
    end else begin
      if (video_valid !== 1'b0) begin
        if (qv.size() == 0) chk(16'h0001, 16'h0000);
        else begin
          chk(video_output, 16'(qv.pop_front()));
          chk(16'(scan_end_pulse), 16'(qs.pop_front()));
        end
      end else if (qv.size() != 0) begin
        // a reset clock rise gave no sample
        chk(16'(qv.size()), 16'h0000);
        qv.delete();
        qs.delete();
      end
      xr = clk_in.charge_transfer_clock && !prv.charge_transfer_clock;
      xf = !clk_in.charge_transfer_clock && prv.charge_transfer_clock;
      rr = clk_in.detector_reset_clock && !prv.detector_reset_clock;
      if (prv.white_ref_clock && !clk_in.white_ref_clock) armed = 1;
      if (xr) begin
        foreach (acc[i]) begin
          well[i] = acc[i];
          acc[i] = 0;
        end
        st = 1;
        line_arm = armed;
        armed = 0;
      end else begin
        if (illum_valid && illum_addr < LCS_NUM_PIX)
          acc[illum_addr] = (acc[illum_addr] + illum_level > 65535) ? 65535
                            : acc[illum_addr] + illum_level;
        if (xf && st == 1) begin
          st = 2;
          seq = 0;
        end
      end
      if (rr && !xr && !xf) begin
        v = 0;
        s = 0;
        if (st == 2) begin
          if (seq >= LCS_BLACK_A_END && seq < LCS_PIX_END) v = well[seq - LCS_BLACK_A_END];
          else if (seq >= LCS_BLACK_B_END && line_arm) v = LCS_WHITE_LEVEL;
          s = line_arm && seq == LCS_BLACK_B_END;
          seq++;
          if (seq == LCS_WHITE_END) st = 0;
        end
        qv.push_back(v);
        qs.push_back(s);
      end
      prv = clk_in;
    end
  end

  initial begin
    void'($urandom(827));
    // random light, with pixel 0 hammered so it saturates; forked after
    // seeding so the light stream inherits the seed; a few addresses lie
    // past the line and must be ignored
    fork
      forever begin
        @(posedge mclk);
        #2;
        illum_valid = !quiet && !sys_rst && $urandom % 2;
        illum_addr = ($urandom % 4 == 0) ? 12'h000 : 12'($urandom % (LCS_NUM_PIX + 64));
        illum_level = (illum_addr == 12'h000) ? 8'hff : 8'($urandom);
        white_hold = (lines % 3 == 2);
      end
    join_none
    repeat (4) @(posedge mclk);
    #2 sys_rst = 1'b0;
    while (lines < 5) @(posedge mclk);
    repeat (4140) @(posedge mclk);
    results();
  end

  initial begin
    #(50 * 4 * LCS_MIN_LINE_PERIODS * 7);
    fails++;
    results();
  end
endmodule
